// ===== rtl/ctm_clk_sel.sv
`timescale 1ns/1ps
`default_nettype none
module ctm_clk_sel #(
   parameter int PW = ctm_pkg::PRESC_W
) (
   input wire logic mclk,
   input wire logic resetn,
   ctm_ctl_if.clk cif
);
   logic [PW-1:0] presc_r;
   logic ext_prev_r;
   logic sel_tick;
   // Prescaler runs only while counting, so it rests with the timer.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         presc_r <= '0;
      end else if (cif.run) begin
         presc_r <= presc_r + 1'b1;
      end else begin
         presc_r <= '0;
      end
   end
   // Previous external level for edge detection.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= cif.ext_in;
      end
   end
   // Source select turns the chosen rate into a one-cycle tick.
   always_comb begin
      case (cif.clk_sel)
         ctm_pkg::CK_SYS_DIV4: sel_tick = &presc_r[ctm_pkg::DIV4_BITS-1:0];
         ctm_pkg::CK_SYS: sel_tick = 1'b1;
         ctm_pkg::CK_H_DIV16: sel_tick = &presc_r[ctm_pkg::DIV16_BITS-1:0];
         ctm_pkg::CK_H_DIV64: sel_tick = &presc_r[ctm_pkg::DIV64_BITS-1:0];
         ctm_pkg::CK_TBC: sel_tick = cif.tb_tick;
         ctm_pkg::CK_H_DIV8: sel_tick = &presc_r[ctm_pkg::DIV8_BITS-1:0];
         ctm_pkg::CK_EXT_RISE: sel_tick = cif.ext_in & ~ext_prev_r;
         ctm_pkg::CK_EXT_FALL: sel_tick = ~cif.ext_in & ext_prev_r;
         default: sel_tick = 1'b0;
      endcase
   end
   // The tick only reaches the counter while it runs.
   assign cif.tick = sel_tick & cif.run;
endmodule
`default_nettype wire

// ===== rtl/ctm_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
// Control and status signals shared by the timer core and its helpers.
interface ctm_ctl_if;
   logic [2:0] clk_sel;
   logic run;
   logic ext_in;
   logic tb_tick;
   logic tick;
   logic [1:0] mode;
   logic [1:0] action;
   logic init_level;
   logic invert;
   logic on_rise;
   logic match_a;
   logic pwm_active;
   logic pin;
   logic oe;
   modport core(output clk_sel, run, ext_in, tb_tick, mode, action,
                init_level, invert, on_rise, match_a, pwm_active,
                input tick, pin, oe);
   modport clk(input clk_sel, run, ext_in, tb_tick, output tick);
   modport out(input mode, action, init_level, invert, on_rise, match_a,
               pwm_active, output pin, oe);
endinterface
`default_nettype wire

// ===== rtl/ctm_out.sv
`timescale 1ns/1ps
`default_nettype none
module ctm_out (
   input wire logic mclk,
   input wire logic resetn,
   ctm_ctl_if.out cif
);
   logic lvl_r;
   logic raw;
   logic pin_r;
   logic oe_r;
   // Compare output level: reload on timer on, act on each A match.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lvl_r <= 1'b0;
      end else if (cif.on_rise) begin
         lvl_r <= cif.init_level;
      end else if (cif.match_a && cif.mode == ctm_pkg::CTM_MODE_CMP) begin
         case (cif.action)
            ctm_pkg::ACT_LOW: if (cif.init_level) lvl_r <= 1'b0;
            ctm_pkg::ACT_HIGH: if (!cif.init_level) lvl_r <= 1'b1;
            ctm_pkg::ACT_TOGGLE: lvl_r <= ~lvl_r;
            default: lvl_r <= lvl_r;
         endcase
      end
   end
   // Level before inversion for each mode.
   always_comb begin
      case (cif.mode)
         ctm_pkg::CTM_MODE_CMP: raw = lvl_r;
         ctm_pkg::CTM_MODE_PWM: begin
            case (cif.action)
               ctm_pkg::PWM_ACTIVE: raw = cif.init_level;
               ctm_pkg::PWM_WAVE: raw = ~(cif.pwm_active ^ cif.init_level);
               default: raw = ~cif.init_level;
            endcase
         end
         default: raw = 1'b0;
      endcase
   end
   // Registered pin and enable; the pin is released in timer mode.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         pin_r <= raw ^ (cif.invert & cif.mode != ctm_pkg::CTM_MODE_TMR);
         oe_r <= cif.mode == ctm_pkg::CTM_MODE_CMP ||
                 cif.mode == ctm_pkg::CTM_MODE_PWM;
      end
   end
   assign cif.pin = pin_r;
   assign cif.oe = oe_r;
endmodule
`default_nettype wire

// ===== rtl/ctm_pkg.sv
`default_nettype none
package ctm_pkg;
   // ==========================================================
   // Register map and reset values.
   localparam logic [7:0] OFF_CTRL0 = 8'h00;
   localparam logic [7:0] OFF_CTRL1 = 8'h04;
   localparam logic [7:0] OFF_CNT_LO = 8'h08;
   localparam logic [7:0] OFF_CNT_HI = 8'h0c;
   localparam logic [7:0] OFF_CMPA_LO = 8'h10;
   localparam logic [7:0] OFF_CMPA_HI = 8'h14;
   localparam logic [7:0] OFF_CMPP = 8'h18;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CMPA_RST = 16'h0000;
   localparam logic [7:0] CMPP_RST = 8'h00;
   // ==========================================================
   // Field positions.
   localparam int HOLD_BIT = 7;
   localparam int CKSEL_LSB = 4;
   localparam int ON_BIT = 3;
   localparam int MODE_LSB = 6;
   localparam int ACT_LSB = 4;
   localparam int INIT_BIT = 3;
   localparam int INV_BIT = 2;
   localparam int SWAP_BIT = 1;
   localparam int CCLR_BIT = 0;
   // ==========================================================
   // Modes, pin actions and clock sources.
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'h0,
      CTM_MODE_UNDEF = 2'h1,
      CTM_MODE_PWM = 2'h2,
      CTM_MODE_TMR = 2'h3
   } ctm_mode_e;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] PWM_INACTIVE = 2'h0;
   localparam logic [1:0] PWM_ACTIVE = 2'h1;
   localparam logic [1:0] PWM_WAVE = 2'h2;
   localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
   localparam logic [2:0] CK_SYS = 3'h1;
   localparam logic [2:0] CK_H_DIV16 = 3'h2;
   localparam logic [2:0] CK_H_DIV64 = 3'h3;
   localparam logic [2:0] CK_TBC = 3'h4;
   localparam logic [2:0] CK_H_DIV8 = 3'h5;
   localparam logic [2:0] CK_EXT_RISE = 3'h6;
   localparam logic [2:0] CK_EXT_FALL = 3'h7;
   // ==========================================================
   // Divider widths: a divide by 2**n fires when n low bits are ones.
   localparam int PRESC_W = 6;
   localparam int DIV4_BITS = 2;
   localparam int DIV8_BITS = 3;
   localparam int DIV16_BITS = 4;
   localparam int DIV64_BITS = 6;
endpackage
`default_nettype wire

// ===== rtl/ctm_top.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ctm_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_input,
   input wire logic time_base_tick,
   output logic timer_output_pin,
   output logic timer_output_oe,
   output logic match_a_event,
   output logic match_p_event
);
   // ==========================================================
   // Registers and decoded fields.
   logic [7:0] ctrl0_r;
   logic [7:0] ctrl1_r;
   logic [15:0] cnt_r;
   logic [15:0] compare_a_value_r;
   logic [7:0] compare_p_value_r;
   logic [31:0] prdata_r;
   logic match_a_event_r;
   logic match_p_event_r;
   logic count_hold;
   logic timer_on;
   logic [2:0] count_clock_select;
   ctm_pkg::ctm_mode_e op_mode_select;
   logic [1:0] pin_action_select;
   logic pin_initial_level;
   logic pin_invert;
   logic period_duty_swap;
   logic clear_source_select;
   logic addr_ok;
   logic wr_en;
   logic wr_lane;
   logic on_rise;
   logic tick;
   logic [15:0] cnt_inc;
   logic hit_a;
   logic hit_p;
   logic cnt_ovf;
   logic clr_now;
   logic ev_a;
   logic ev_p;
   logic pwm_active;
   logic pwm_exp;
   logic [7:0] rd_byte;
   ctm_ctl_if cif();

   // Field aliases of the two control registers.
   assign count_hold = ctrl0_r[ctm_pkg::HOLD_BIT];
   assign timer_on = ctrl0_r[ctm_pkg::ON_BIT];
   assign count_clock_select = ctrl0_r[ctm_pkg::CKSEL_LSB +: 3];
   assign op_mode_select =
      ctm_pkg::ctm_mode_e'(ctrl1_r[ctm_pkg::MODE_LSB +: 2]);
   assign pin_action_select = ctrl1_r[ctm_pkg::ACT_LSB +: 2];
   assign pin_initial_level = ctrl1_r[ctm_pkg::INIT_BIT];
   assign pin_invert = ctrl1_r[ctm_pkg::INV_BIT];
   assign period_duty_swap = ctrl1_r[ctm_pkg::SWAP_BIT];
   assign clear_source_select = ctrl1_r[ctm_pkg::CCLR_BIT];

   // ==========================================================
   // APB slave: zero wait states, error on unmapped addresses.
   always_comb begin
      case (paddr)
         ctm_pkg::OFF_CTRL0: addr_ok = 1'b1;
         ctm_pkg::OFF_CTRL1: addr_ok = 1'b1;
         ctm_pkg::OFF_CNT_LO: addr_ok = 1'b1;
         ctm_pkg::OFF_CNT_HI: addr_ok = 1'b1;
         ctm_pkg::OFF_CMPA_LO: addr_ok = 1'b1;
         ctm_pkg::OFF_CMPA_HI: addr_ok = 1'b1;
         ctm_pkg::OFF_CMPP: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign wr_lane = wr_en & pstrb[0];
   assign on_rise = wr_lane && paddr == ctm_pkg::OFF_CTRL0 &&
                    pwdata[ctm_pkg::ON_BIT] && !timer_on;

   // Control register zero; low three bits are not stored.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl0_r <= ctm_pkg::CTRL0_RST;
      end else if (wr_lane && paddr == ctm_pkg::OFF_CTRL0) begin
         ctrl0_r <= {pwdata[7:3], 3'h0};
      end
   end
   // Control register one.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl1_r <= ctm_pkg::CTRL1_RST;
      end else if (wr_lane && paddr == ctm_pkg::OFF_CTRL1) begin
         ctrl1_r <= pwdata[7:0];
      end
   end
   // Compare values; each byte is written directly.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         compare_a_value_r <= ctm_pkg::CMPA_RST;
         compare_p_value_r <= ctm_pkg::CMPP_RST;
      end else if (wr_lane) begin
         if (paddr == ctm_pkg::OFF_CMPA_LO) begin
            compare_a_value_r[7:0] <= pwdata[7:0];
         end
         if (paddr == ctm_pkg::OFF_CMPA_HI) begin
            compare_a_value_r[15:8] <= pwdata[7:0];
         end
         if (paddr == ctm_pkg::OFF_CMPP) begin
            compare_p_value_r <= pwdata[7:0];
         end
      end
   end
   // Read byte selection.
   always_comb begin
      case (paddr)
         ctm_pkg::OFF_CTRL0: rd_byte = ctrl0_r;
         ctm_pkg::OFF_CTRL1: rd_byte = ctrl1_r;
         ctm_pkg::OFF_CNT_LO: rd_byte = cnt_r[7:0];
         ctm_pkg::OFF_CNT_HI: rd_byte = cnt_r[15:8];
         ctm_pkg::OFF_CMPA_LO: rd_byte = compare_a_value_r[7:0];
         ctm_pkg::OFF_CMPA_HI: rd_byte = compare_a_value_r[15:8];
         ctm_pkg::OFF_CMPP: rd_byte = compare_p_value_r;
         default: rd_byte = 8'h00;
      endcase
   end
   // Read data is captured in the setup cycle and held for the access.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= {24'h00_0000, rd_byte};
      end
   end
   assign prdata = prdata_r;

   // ==========================================================
   // Comparators and clear decision.
   assign cnt_inc = cnt_r + 16'h0001;
   assign cnt_ovf = cnt_r == 16'hffff;
   // A zero compare A would only match at wrap, which raises no event.
   assign hit_a = cnt_inc == compare_a_value_r &&
                  compare_a_value_r != 16'h0000;
   // Upper byte reaching N after N*256 steps; zero means run to wrap.
   assign hit_p = cnt_inc[15:8] == compare_p_value_r &&
                  compare_p_value_r != 8'h00;
   always_comb begin
      if (op_mode_select == ctm_pkg::CTM_MODE_PWM) begin
         clr_now = period_duty_swap ? hit_a : hit_p;
      end else begin
         clr_now = clear_source_select ? hit_a : hit_p;
      end
   end
   // Event pulses; P events are suppressed when A clears outside PWM.
   assign ev_a = tick & hit_a & ~on_rise;
   assign ev_p = tick & ~on_rise &
                 (hit_p | (cnt_ovf & compare_p_value_r == 8'h00)) &
                 ~(clear_source_select &
                   op_mode_select != ctm_pkg::CTM_MODE_PWM);

   // Counter: cleared by timer on, else stepped or cleared per tick.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= ctm_pkg::CNT_RST;
      end else if (on_rise) begin
         cnt_r <= 16'h0000;
      end else if (tick) begin
         cnt_r <= clr_now ? 16'h0000 : cnt_inc;
      end
   end
   // Registered request pulses.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         match_a_event_r <= 1'b0;
         match_p_event_r <= 1'b0;
      end else begin
         match_a_event_r <= ev_a;
         match_p_event_r <= ev_p;
      end
   end
   assign match_a_event = match_a_event_r;
   assign match_p_event = match_p_event_r;

   // PWM duty comparison against the duty source.
   assign pwm_active = period_duty_swap ?
                       cnt_r[15:8] < compare_p_value_r :
                       cnt_r < compare_a_value_r;
   assign pwm_exp = ~(pwm_active ^ pin_initial_level) ^ pin_invert;

   // ==========================================================
   // Helper connections.
   assign cif.clk_sel = count_clock_select;
   assign cif.run = timer_on & ~count_hold;
   assign cif.ext_in = ext_count_input;
   assign cif.tb_tick = time_base_tick;
   assign cif.mode = op_mode_select;
   assign cif.action = pin_action_select;
   assign cif.init_level = pin_initial_level;
   assign cif.invert = pin_invert;
   assign cif.on_rise = on_rise;
   assign cif.match_a = ev_a;
   assign cif.pwm_active = pwm_active;
   assign tick = cif.tick;
   assign timer_output_pin = cif.pin;
   assign timer_output_oe = cif.oe;

   ctm_clk_sel #(.PW(ctm_pkg::PRESC_W)) u_clk (
      .mclk(mclk),
      .resetn(resetn),
      .cif(cif.clk)
   );
   ctm_out u_out (
      .mclk(mclk),
      .resetn(resetn),
      .cif(cif.out)
   );

   // ==========================================================
   // Checks beside the logic.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   on_clear_a: assert property (on_rise |=> cnt_r == 16'h0000)
      else $error("Counter not cleared by timer on.");
   hold_freeze_a: assert property (count_hold && !on_rise |=>
      $stable(cnt_r))
      else $error("Counter moved while held.");
   off_keep_a: assert property (!timer_on && !on_rise |=>
      $stable(cnt_r))
      else $error("Counter moved while off.");
   count_step_a: assert property (tick && !clr_now && !on_rise |=>
      cnt_r == $past(cnt_inc))
      else $error("Counter did not step by one.");
   p_clear_a: assert property (tick && hit_p && !on_rise &&
      op_mode_select == ctm_pkg::CTM_MODE_CMP && !clear_source_select
      |=> cnt_r == 16'h0000 && match_p_event)
      else $error("P match did not clear the counter.");
   a_clear_a: assert property (tick && hit_a && !on_rise &&
      op_mode_select == ctm_pkg::CTM_MODE_CMP && clear_source_select
      |=> cnt_r == 16'h0000 && match_a_event && !match_p_event)
      else $error("A match did not clear the counter.");
   init_level_a: assert property ((on_rise &&
      op_mode_select == ctm_pkg::CTM_MODE_CMP) ##1 (!ev_a &&
      op_mode_select == ctm_pkg::CTM_MODE_CMP) |=> timer_output_pin ==
      ($past(pin_initial_level) ^ $past(pin_invert)))
      else $error("Pin not restored to initial level.");
   tmr_release_a: assert property (op_mode_select ==
      ctm_pkg::CTM_MODE_TMR |=> !timer_output_oe)
      else $error("Pin driven in timer mode.");
   pwm_wave_a: assert property (op_mode_select == ctm_pkg::CTM_MODE_PWM &&
      pin_action_select == ctm_pkg::PWM_WAVE |=> timer_output_pin ==
      $past(pwm_exp))
      else $error("PWM pin level wrong.");
   sys_tick_a: assert property (cif.run &&
      count_clock_select == ctm_pkg::CK_SYS |-> tick)
      else $error("System clock source did not tick.");

   cov_match_a: cover property (ev_a ##1 match_a_event);
   cov_match_p: cover property (ev_p ##1 match_p_event);
   cov_restart: cover property (on_rise ##1 tick);
   cov_pwm_run: cover property (op_mode_select == ctm_pkg::CTM_MODE_PWM &&
      tick && clr_now);
endmodule
`default_nettype wire

// ===== sim/compact_timer_module_16bit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module compact_timer_module_16bit_tb;
   localparam int EXT_HALF = 3;
   localparam int TB_PER = 5;
   logic mclk;
   logic resetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [3:0] pstrb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_count_input;
   logic time_base_tick;
   logic timer_output_pin;
   logic timer_output_oe;
   logic match_a_event;
   logic match_p_event;
   logic ext_run;
   int fails;
   int comparisons;
   int seed;
   // ==========================================================
   // Design and far side.
   ctm_top ctm_top_inst (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_input(ext_count_input), .time_base_tick(time_base_tick),
      .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
      .match_a_event(match_a_event), .match_p_event(match_p_event));
   ctm_far_end #(.EXT_HALF(EXT_HALF), .TB_PER(TB_PER)) ctm_far_end_inst (
      .mclk(mclk), .resetn(resetn), .ext_run(ext_run),
      .ext_count_input(ext_count_input), .time_base_tick(time_base_tick));
   // ==========================================================
   // Helpers: bus cycles, comparison and expectations.
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, x);
      end
   endtask
   // One idle cycle first, so a release and a new setup never share a step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         $display("CHECK FAILED at %0t: no bus answer", $time);
      end
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic e;
      apb(1'b0, a, 8'h00, d, e);
   endtask
   task automatic rd16(output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(ctm_pkg::OFF_CNT_LO, lo);
      rd(ctm_pkg::OFF_CNT_HI, hi);
      v = {hi, lo};
   endtask
   task automatic setab(input logic [15:0] a, input logic [7:0] p);
      wr(ctm_pkg::OFF_CMPA_LO, a[7:0]);
      wr(ctm_pkg::OFF_CMPA_HI, a[15:8]);
      wr(ctm_pkg::OFF_CMPP, p);
   endtask
   // Timer is switched off before any control change, then restarted.
   task automatic start(input logic [2:0] ck, input logic [7:0] c1);
      wr(ctm_pkg::OFF_CTRL0, 8'h00);
      wr(ctm_pkg::OFF_CTRL1, c1);
      wr(ctm_pkg::OFF_CTRL0, {1'b0, ck, 1'b1, 3'h0});
   endtask
   task automatic wait_ev(input logic p, output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while ((p ? match_p_event : match_a_event) !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         fails++;
         $display("CHECK FAILED at %0t: no match event", $time);
      end
   endtask
   task automatic ev_gap(input logic p, output int g);
      wait_ev(p, g);
      wait_ev(p, g);
   endtask
   function automatic int ticks_per(input logic [2:0] c);
      case (c)
         ctm_pkg::CK_SYS_DIV4: return 4;
         ctm_pkg::CK_SYS: return 1;
         ctm_pkg::CK_H_DIV16: return 16;
         ctm_pkg::CK_H_DIV64: return 64;
         ctm_pkg::CK_TBC: return TB_PER;
         ctm_pkg::CK_H_DIV8: return 8;
         default: return 2 * EXT_HALF;
      endcase
   endfunction
   function automatic logic pin_exp(input int act, input logic init);
      case (act)
         1: return 1'b0;
         2: return 1'b1;
         3: return ~init;
         default: return init;
      endcase
   endfunction
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and the test sequence.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      report_and_stop();
   end
   initial begin
      logic [7:0] d;
      logic [7:0] rv;
      logic e;
      logic [15:0] h;
      logic [15:0] v;
      int g;
      int n;
      fails = 0;
      comparisons = 0;
      seed = 32'had7d;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'hf;
      ext_run = 1'b0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      // Reset values, reserved bits, read-only counter, unmapped place.
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(i * 4), 8'h00, d, e);
         check(32'({e, d}), (i == 7) ? 32'h100 : 32'h0);
      end
      d = (8'($random(seed)) | 8'h07) & 8'hf7;
      wr(ctm_pkg::OFF_CTRL0, d);
      rd(ctm_pkg::OFF_CTRL0, rv);
      check(32'(rv), 32'(d & 8'hf0));
      wr(ctm_pkg::OFF_CNT_LO, 8'h55);
      rd(ctm_pkg::OFF_CNT_LO, rv);
      check(32'(rv), 32'h0);
      $display("test registers done");
      // Every clock source with a random compare A period.
      for (int c = 0; c < 8; c++) begin
         n = 2 + $unsigned($random(seed)) % 6;
         ext_run <= (c >= 6);
         setab(16'(n), 8'h00);
         start(3'(c), 8'hc1);
         ev_gap(1'b0, g);
         check(32'(g), 32'(n * ticks_per(3'(c))));
      end
      ext_run <= 1'b0;
      // Compare P period on the upper byte, while A matches meanwhile.
      n = 1 + $unsigned($random(seed)) % 3;
      setab(16'h0010, 8'(n));
      start(ctm_pkg::CK_SYS, 8'h00);
      ev_gap(1'b1, g);
      check(32'(g), 32'(256 * n));
      $display("test clocks and periods done");
      // Pin actions and initial levels in compare output mode.
      setab(16'h0028, 8'h00);
      for (int a = 0; a < 8; a++) begin
         rv = 8'($random(seed)) & 8'h04;
         start(ctm_pkg::CK_SYS, 8'(a * 8) | rv | 8'h01);
         repeat (6) @(posedge mclk);
         check(32'(timer_output_pin), 32'((a & 1) ^ rv[2]));
         wait_ev(1'b0, g);
         repeat (3) @(posedge mclk);
         check(32'(timer_output_pin),
               32'(pin_exp(a >> 1, 1'(a & 1)) ^ rv[2]));
      end
      $display("test pin actions done");
      // PWM waveform with both period and duty assignments.
      for (int s = 0; s < 2; s++) begin
         d = 8'h10 + 8'($unsigned($random(seed)) % 200);
         setab((s == 1) ? 16'h0258 : {8'h00, d}, 8'h01);
         start(ctm_pkg::CK_SYS, 8'ha8 | 8'(s * 2));
         ev_gap(s == 0, g);
         check(32'(g), (s == 1) ? 32'd600 : 32'd256);
         n = 0;
         repeat (g) begin
            @(posedge mclk);
            n += (timer_output_pin === 1'b1) ? 1 : 0;
         end
         check(32'(n), (s == 1) ? 32'd256 : 32'(d));
      end
      for (int a = 0; a < 4; a++) begin
         start(ctm_pkg::CK_SYS, 8'h80 | 8'(a * 8));
         repeat (6) @(posedge mclk);
         check(32'(timer_output_pin), 32'((a >> 1) == (a & 1)));
      end
      $display("test pwm done");
      // Hold, resume, off with residual value, and clear on restart.
      setab(16'h0000, 8'h00);
      start(ctm_pkg::CK_SYS, 8'hc1);
      repeat (100) @(posedge mclk);
      wr(ctm_pkg::OFF_CTRL0, 8'h98);
      rd16(h);
      repeat (20) @(posedge mclk);
      rd16(v);
      check(32'(v), 32'(h));
      wr(ctm_pkg::OFF_CTRL0, 8'h18);
      repeat (30) @(posedge mclk);
      wr(ctm_pkg::OFF_CTRL0, 8'h98);
      rd16(v);
      check(32'(v > h), 32'h1);
      wr(ctm_pkg::OFF_CTRL0, 8'h10);
      rd16(h);
      repeat (20) @(posedge mclk);
      rd16(v);
      check(32'({v == h, h != 16'h0000}), 32'h3);
      wr(ctm_pkg::OFF_CTRL0, 8'h18);
      rd16(v);
      check(32'(v < 16'h0010), 32'h1);
      // Output enable for each operating mode.
      for (int m = 0; m < 4; m++) begin
         start(ctm_pkg::CK_SYS, 8'(m * 64));
         repeat (3) @(posedge mclk);
         check(32'(timer_output_oe), 32'(m == 0 || m == 2));
      end
      $display("test hold and modes done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== sim/ctm_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side model: external count source and time-base ticks.
module ctm_far_end #(
   parameter int EXT_HALF = 3,
   parameter int TB_PER = 5
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ext_run,
   output logic ext_count_input,
   output logic time_base_tick
);
   int ext_cnt;
   int tb_cnt;
   // Square wave on the count input; it stands still while not running.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ext_cnt <= 0;
         ext_count_input <= 1'b0;
      end else if (ext_run) begin
         ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
         if (ext_cnt == EXT_HALF - 1) begin
            ext_count_input <= ~ext_count_input;
         end
      end
   end
   // One-cycle time-base pulse every TB_PER cycles.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tb_cnt <= 0;
         time_base_tick <= 1'b0;
      end else begin
         tb_cnt <= (tb_cnt == TB_PER - 1) ? 0 : tb_cnt + 1;
         time_base_tick <= (tb_cnt == TB_PER - 1);
      end
   end
endmodule
`default_nettype wire
